// >>> hdl/swr_params.svh
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

// Clock rate and link timing figures (times in ns).
`define SWR_CLK_MHZ          250
`define SWR_BREAK_NS         190000
`define SWR_HOST_ONE_LOW_NS  32000
`define SWR_HOST_ZERO_LOW_NS 100000
`define SWR_DEV_SLOT_NS      190000
`define SWR_DEV_ONE_LOW_NS   32000
`define SWR_DEV_ZERO_LOW_NS  100000

// Every time rounds up; the threshold sits midway and rounds down.
`define SWR_BREAK_CYC ((`SWR_BREAK_NS * `SWR_CLK_MHZ + 999) / 1000)
`define SWR_THRESH_CYC \
  (((`SWR_HOST_ONE_LOW_NS + `SWR_HOST_ZERO_LOW_NS) / 2) * `SWR_CLK_MHZ / 1000)
`define SWR_DEV_SLOT_CYC ((`SWR_DEV_SLOT_NS * `SWR_CLK_MHZ + 999) / 1000)
`define SWR_DEV_ONE_CYC ((`SWR_DEV_ONE_LOW_NS * `SWR_CLK_MHZ + 999) / 1000)
`define SWR_DEV_ZERO_CYC ((`SWR_DEV_ZERO_LOW_NS * `SWR_CLK_MHZ + 999) / 1000)

// Command byte layout, direction encoding and request buffer depth.
`define SWR_RW_BIT   7
`define SWR_RW_WRITE 1'b1
`define SWR_BUF_DEPTH 2

`endif

// >>> hdl/swr_pkg.sv
package swr_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_BRK  = 7'b0000010,
    ST_CMD  = 7'b0000100,
    ST_WDAT = 7'b0001000,
    ST_PUSH = 7'b0010000,
    ST_WAIT = 7'b0100000,
    ST_SEND = 7'b1000000
  } swr_state_t;

  typedef struct packed {
    swr_state_t        state;
    logic              loaded;
    logic              mode_sw;
    logic              on_alert;
    logic              line_q;
    logic [16:0]       low_cnt;
    logic [16:0]       slot_cnt;
    logic [3:0]        bit_cnt;
    logic [7:0]        shreg;
    logic [7:0]        cmd;
    logic [7:0]        tx;
    logic              rd_ready;
    logic              alert_oe;
    logic              dedic_oe;
    logic [1:0][15:0]  bufd;
    logic [1:0]        buf_cnt;
    logic              req_valid;
  } swr_regs_t;

endpackage : swr_pkg

// >>> hdl/single_wire_responder_port.sv
`timescale 1ns/1ps
`include "swr_params.svh"

module single_wire_responder_port
  import swr_pkg::*;
#(
  parameter int BREAK_CYC    = `SWR_BREAK_CYC,
  parameter int THRESH_CYC   = `SWR_THRESH_CYC,
  parameter int DEV_SLOT_CYC = `SWR_DEV_SLOT_CYC,
  parameter int DEV_ONE_CYC  = `SWR_DEV_ONE_CYC,
  parameter int DEV_ZERO_CYC = `SWR_DEV_ZERO_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Interrupt output pin used as single-wire line
  input  wire logic        alert_in,
  output logic             alert_out,
  output logic             alert_oe,
  // Dedicated single-wire pin
  input  wire logic        single_wire_port_in,
  output logic             single_wire_port_out,
  output logic             single_wire_port_oe,
  // Configuration and mode-change subcommands
  input  wire logic        cfg_single_wire,
  input  wire logic        cfg_on_alert,
  input  wire logic        switch_to_single_wire_cmd,
  input  wire logic        switch_to_configured_cmd,
  output logic             single_wire_mode,
  output logic             link_on_alert,
  // Transaction requests toward the register core
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic             req_write,
  output logic [6:0]       req_code,
  output logic [7:0]       req_data,
  // Read data returned by the register core
  input  wire logic        rd_valid,
  output logic             rd_ready,
  input  wire logic [7:0]  rd_data
);

  localparam logic [16:0] BREAK_C  = 17'(BREAK_CYC);
  localparam logic [16:0] THRESH_C = 17'(THRESH_CYC);
  localparam logic [16:0] SLOT_C   = 17'(DEV_SLOT_CYC);
  localparam logic [16:0] ONE_C    = 17'(DEV_ONE_CYC);
  localparam logic [16:0] ZERO_C   = 17'(DEV_ZERO_CYC);
  localparam logic [1:0]  DEPTH_C  = 2'(`SWR_BUF_DEPTH);

  swr_regs_t s;
  swr_regs_t next_s;

  // A short host low pulse is a one, a long one a zero.
  function automatic logic host_bit(input logic [16:0] low_len);
    host_bit = (low_len < THRESH_C);
  endfunction : host_bit

  logic       line;
  logic       rise;
  logic [7:0] shifted;
  logic [1:0] cnt;
  logic [16:0] low_len;

  always_comb
  begin
    next_s  = s;
    line    = s.on_alert ? alert_in : single_wire_port_in;
    rise    = ~s.line_q & line;
    shifted = {host_bit(s.low_cnt), s.shreg[7:1]};
    cnt     = s.buf_cnt;
    low_len = ZERO_C;
    next_s.line_q = line;

    if (line)
    begin
      next_s.low_cnt = '0;
    end
    else if (s.low_cnt != '1)
    begin
      next_s.low_cnt = s.low_cnt + 17'd1;
    end

    // The head entry leaves when the core takes it.
    if (req_ready && s.req_valid)
    begin
      next_s.bufd[0] = s.bufd[1];
      cnt = s.buf_cnt - 2'd1;
    end

    case (s.state)
      ST_IDLE:
      begin
        if (s.mode_sw && !line && s.low_cnt == BREAK_C - 17'd1)
        begin
          next_s.state = ST_BRK;
        end
      end
      ST_BRK:
      begin
        if (rise)
        begin
          next_s.state   = ST_CMD;
          next_s.bit_cnt = '0;
        end
      end
      ST_CMD, ST_WDAT:
      begin
        if (!line && s.low_cnt == BREAK_C - 17'd1)
        begin
          next_s.state = ST_BRK;
        end
        else if (rise)
        begin
          next_s.shreg   = shifted;
          next_s.bit_cnt = s.bit_cnt + 4'd1;
          if (s.bit_cnt == 4'd7)
          begin
            next_s.bit_cnt = '0;
            if (s.state == ST_CMD)
            begin
              next_s.cmd = shifted;
              // Direction flag in bit 7 picks the data phase.
              next_s.state = (shifted[`SWR_RW_BIT] == `SWR_RW_WRITE) ? ST_WDAT
                                                                     : ST_PUSH;
            end
            else
            begin
              next_s.state = ST_PUSH;
            end
          end
        end
      end
      ST_PUSH:
      begin
        // Waits here while the buffer is full, so no word is lost.
        if (cnt < DEPTH_C)
        begin
          next_s.bufd[cnt[0]] = {s.cmd, s.shreg};
          cnt = cnt + 2'd1;
          if (s.cmd[`SWR_RW_BIT] == `SWR_RW_WRITE)
          begin
            next_s.state = ST_IDLE;
          end
          else
          begin
            next_s.state    = ST_WAIT;
            next_s.rd_ready = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (rd_valid && s.rd_ready)
        begin
          next_s.tx       = rd_data;
          next_s.rd_ready = 1'b0;
          next_s.slot_cnt = '0;
          next_s.bit_cnt  = '0;
          next_s.state    = ST_SEND;
        end
      end
      ST_SEND:
      begin
        next_s.slot_cnt = s.slot_cnt + 17'd1;
        if (s.slot_cnt == SLOT_C - 17'd1)
        begin
          next_s.slot_cnt = '0;
          next_s.bit_cnt  = s.bit_cnt + 4'd1;
          if (s.bit_cnt == 4'd7)
          begin
            next_s.state = ST_IDLE;
          end
        end
      end
      default:
      begin
        next_s.state = ST_IDLE;
      end
    endcase

    next_s.buf_cnt   = cnt;
    next_s.req_valid = (cnt != 2'd0);

    // Mode control: configuration at start, subcommands switch at once.
    if (!s.loaded)
    begin
      next_s.loaded   = 1'b1;
      next_s.mode_sw  = cfg_single_wire;
      next_s.on_alert = cfg_on_alert;
    end
    else if (switch_to_single_wire_cmd)
    begin
      next_s.mode_sw  = 1'b1;
      next_s.on_alert = 1'b1;
    end
    else if (switch_to_configured_cmd)
    begin
      next_s.mode_sw  = cfg_single_wire;
      next_s.on_alert = cfg_on_alert;
    end
    if (next_s.mode_sw != s.mode_sw || next_s.on_alert != s.on_alert)
    begin
      next_s.state    = ST_IDLE;
      next_s.rd_ready = 1'b0;
    end

    // Device bit: low for its zero or one time, then released to slot end.
    if (next_s.tx[next_s.bit_cnt[2:0]])
    begin
      low_len = ONE_C;
    end
    next_s.alert_oe = (next_s.state == ST_SEND) && next_s.on_alert &&
                      (next_s.slot_cnt < low_len);
    next_s.dedic_oe = (next_s.state == ST_SEND) && !next_s.on_alert &&
                      (next_s.slot_cnt < low_len);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s       <= '0;
      s.state <= ST_IDLE;
      s.line_q <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Open drain: the driven level is always low; the enable pulls the line.
  assign alert_out            = 1'b0;
  assign single_wire_port_out = 1'b0;
  assign alert_oe             = s.alert_oe;
  assign single_wire_port_oe  = s.dedic_oe;
  assign single_wire_mode     = s.mode_sw;
  assign link_on_alert        = s.on_alert;
  assign req_valid            = s.req_valid;
  assign req_write            = s.bufd[0][15];
  assign req_code             = s.bufd[0][14:8];
  assign req_data             = s.bufd[0][7:0];
  assign rd_ready             = s.rd_ready;

endmodule : single_wire_responder_port

// >>> verification/swr_properties.sv
`timescale 1ns/1ps
module swr_properties
  import swr_pkg::*;
#(
  parameter int DEV_ONE_CYC  = 5,
  parameter int DEV_ZERO_CYC = 15
) (
  // Clock, reset and pins
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       alert_out,
  input wire logic       alert_oe,
  input wire logic       single_wire_port_out,
  input wire logic       single_wire_port_oe,
  // Mode and core side
  input wire logic       cfg_single_wire,
  input wire logic       cfg_on_alert,
  input wire logic       switch_to_single_wire_cmd,
  input wire logic       switch_to_configured_cmd,
  input wire logic       single_wire_mode,
  input wire logic       link_on_alert,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       req_write,
  input wire logic [6:0] req_code,
  input wire logic [7:0] req_data,
  input wire logic       rd_valid,
  input wire logic       rd_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_pins_pull_low: assert property (!alert_out && !single_wire_port_out)
    else $error("pin data not low");
  a_pin_choice: assert property ((alert_oe -> link_on_alert) && (single_wire_port_oe -> !link_on_alert))
    else $error("wrong pin driven");
  a_quiet_off_mode: assert property (!single_wire_mode |=> !alert_oe && !single_wire_port_oe)
    else $error("driven outside mode");
  a_read_starts: assert property (rd_valid && rd_ready |=> alert_oe || single_wire_port_oe)
    else $error("read slot late");
  a_read_waits: assert property (rd_ready && !rd_valid |=> rd_ready)
    else $error("read wait dropped");
  a_slot_low: assert property ($fell(alert_oe) |->
    ($past(alert_oe, DEV_ONE_CYC) && !$past(alert_oe, DEV_ONE_CYC + 1)) ||
    ($past(alert_oe, DEV_ZERO_CYC) && !$past(alert_oe, DEV_ZERO_CYC + 1)))
    else $error("slot low time wrong");
  a_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable({req_write, req_code, req_data}))
    else $error("request not held");
  a_swap_single: assert property (switch_to_single_wire_cmd |=> single_wire_mode && link_on_alert)
    else $error("single switch failed");
  a_swap_cfg: assert property (switch_to_configured_cmd && !switch_to_single_wire_cmd |=>
    single_wire_mode == $past(cfg_single_wire) && link_on_alert == $past(cfg_on_alert))
    else $error("configured switch failed");
endmodule : swr_properties

bind single_wire_responder_port swr_properties #(.DEV_ONE_CYC(DEV_ONE_CYC),
  .DEV_ZERO_CYC(DEV_ZERO_CYC)) props (.*);

// >>> verification/swr_host.sv
`timescale 1ns/1ps
module swr_host (
  // Clock and wire level
  input  wire logic clk,
  input  wire logic line,
  // Pull-down enable
  output logic      oe
);
  initial oe = 1'b0;

  task automatic low_high(input int lo, input int hi);
    repeat (lo) @(posedge clk) oe <= 1'b1;
    repeat (hi) @(posedge clk) oe <= 1'b0;
  endtask : low_high

  task automatic send(input logic [15:0] w, input int n);
    low_high(45, 10);
    // A read command frees the line at once, since the device answers within cycles.
    for (int i = 0; i < n; i++)
      low_high(w[i] ? 4 : 16, (i == n - 1 && n == 8) ? 1 : (w[i] ? 20 : 8));
  endtask : send

  task automatic get(output logic [7:0] b);
    int c;
    b = 8'h00;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      c = 0;
      while (line && c < 2000) begin @(posedge clk); c++; end
      c = 0;
      while (!line) begin @(posedge clk); c++; end
      b[i] = (c < 10);
    end
  endtask : get
endmodule : swr_host

// >>> verification/single_wire_responder_port_test.sv
`timescale 1ns/1ps
module single_wire_responder_port_test;
  logic        clk, srst, cfg_single_wire, cfg_on_alert, req_ready, rd_valid;
  logic        switch_to_single_wire_cmd, switch_to_configured_cmd, on_alert, stall;
  logic        alert_out, alert_oe, single_wire_port_out, single_wire_port_oe;
  logic        single_wire_mode, link_on_alert, req_valid, req_write, rd_ready, h_oe;
  logic [6:0]  req_code;
  logic [7:0]  req_data, rd_data, rd_byte;
  logic [15:0] exp_q[$];
  int          fail_count, tests_run;
  // Open-drain wires with pullups; the host sits on the selected pin.
  wire alert_in            = !((h_oe && on_alert) || alert_oe);
  wire single_wire_port_in = !((h_oe && !on_alert) || single_wire_port_oe);

  single_wire_responder_port #(.BREAK_CYC(40), .THRESH_CYC(10), .DEV_SLOT_CYC(30),
    .DEV_ONE_CYC(5), .DEV_ZERO_CYC(15)) dut (.*);
  swr_host host (.clk(clk), .line(on_alert ? alert_in : single_wire_port_in), .oe(h_oe));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic wr(input logic [6:0] code, input logic [7:0] d);
    exp_q.push_back({1'b1, code, d});
    host.send({d, 1'b1, code}, 16);
  endtask : wr

  task automatic rd(input logic [6:0] code);
    logic [7:0] b;
    rd_byte = $urandom;
    exp_q.push_back({1'b0, code, 8'h00});
    host.send({8'h00, 1'b0, code}, 8);
    host.get(b);
    check(16'(b), 16'(rd_byte));
    repeat (40) @(posedge clk);
  endtask : rd

  task automatic pulse(input logic single);
    @(posedge clk);
    if (single) switch_to_single_wire_cmd <= 1'b1;
    else switch_to_configured_cmd <= 1'b1;
    @(posedge clk);
    switch_to_single_wire_cmd <= 1'b0;
    switch_to_configured_cmd  <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // The register core accepts with random stalls and answers reads one cycle after rd_ready.
  always @(posedge clk)
  begin : core
    logic [15:0] e;
    req_ready <= !stall && 1'($urandom_range(1, 0));
    rd_valid  <= rd_ready && !rd_valid;
    rd_data   <= rd_byte;
    if (req_valid && req_ready)
    begin
      e = exp_q.pop_front();
      if (!e[15]) e[7:0] = req_data;
      check({req_write, req_code, req_data}, e);
    end
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    results();
  end

  initial
  begin
    void'($urandom(55));
    {srst, cfg_single_wire, cfg_on_alert, on_alert, stall} = 5'h1f;
    {req_ready, rd_valid, switch_to_single_wire_cmd, switch_to_configured_cmd} = 4'h0;
    rd_data = 8'h00;
    rd_byte = 8'h00;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    check({single_wire_mode, link_on_alert}, 16'h3);
    $display("reset test done");
    repeat (3) wr($urandom, $urandom);
    check(16'(req_valid), 16'h1);
    stall = 1'b0;
    repeat (6) wr($urandom, $urandom);
    $display("write test done");
    repeat (4) rd($urandom);
    $display("read test done");
    cfg_single_wire <= 1'b0;
    pulse(1'b0);
    check(16'(single_wire_mode), 16'h0);
    host.send({8'h5a, 8'ha5}, 16);
    repeat (50) @(posedge clk);
    check(16'(req_valid), 16'h0);
    cfg_single_wire <= 1'b1;
    cfg_on_alert    <= 1'b0;
    pulse(1'b0);
    on_alert = 1'b0;
    check({single_wire_mode, link_on_alert}, 16'h2);
    rd($urandom);
    wr($urandom, $urandom);
    pulse(1'b1);
    on_alert = 1'b1;
    check({single_wire_mode, link_on_alert}, 16'h3);
    rd($urandom);
    $display("mode test done");
    repeat (100) @(posedge clk);
    results();
  end
endmodule : single_wire_responder_port_test
